/* File: hdl/hcpl_params.svh */
// What this block does
// [R01] The heater is modulated over a repeating frame of exactly ten mains cycles, decided per whole cycle.
// [R02] Duty step N (0..10) turns the heater on for N cycles and off for 10-N, by one fixed pattern per step.
// [R03] With limiting on and average current above the limit, duty drops by one step.
// [R04] With limiting on and average current below the limit, duty rises by one step, up to full.
// [R05] Duty is held until the measured current has settled at that duty before any adjustment.
// [R06] When heat becomes requested from off, duty starts at zero and ramps up one step at a time.
// [R07] The heater switches only at mains zero crossings, so it conducts for whole cycles; the code also forces it off on the clock after a trip.
// [R08] Each measurement takes 300 samples started on a zero crossing, spanning ten mains cycles.
// [R09] Heater current, earth leakage current and voltage are taken as 10-bit values.
// [R10] Expected average current is full-duty current times the present duty fraction.
// [R11] The limit accepts 0.1 A to 30 A, or an off value that disables limiting and leaves full duty.
// [R12] On an earth leakage trip the heater loses power within 7.4 seconds of the fault.
// [R13] A new duty step is applied only at a frame boundary.
// [R14] The heater stays off for the whole frame while heat is not requested.
`ifndef HCPL_PARAMS_SVH
`define HCPL_PARAMS_SVH
`define HCPL_FRAME_CYCLES 4'hA
`define HCPL_DUTY_FULL 4'hA
`define HCPL_SAMPLES 9'h12C
`define HCPL_ADC_W 10
`define HCPL_LIMIT_OFF 10'h000
`define HCPL_LIMIT_MAX 10'h12C
`define HCPL_SETTLE_FRAMES 2'h2
`define HCPL_CLK_HZ 125000000
`define HCPL_TRIP_MS 7400
`define HCPL_TRIP_MARGIN_MS 400
`define HCPL_TRIP_CYCLES ((`HCPL_CLK_HZ / 1000) * (`HCPL_TRIP_MS - `HCPL_TRIP_MARGIN_MS))
`define HCPL_PACE_DIV 32'd25000
`define HCPL_TRIP_TICKS ((`HCPL_TRIP_MS - `HCPL_TRIP_MARGIN_MS) * 5)
`endif

/* File: hdl/hcpl_pkg.sv */
`default_nettype none
package hcpl_pkg;
  typedef logic [9:0] hcpl_adc_t;
  typedef struct packed {
    hcpl_adc_t heater_current;
    hcpl_adc_t earth_leakage_current;
    hcpl_adc_t voltage;
  } hcpl_meas_s;
  typedef enum logic [1:0] {
    HCPL_ST_OFF = 2'b00,
    HCPL_ST_SETTLE = 2'b01,
    HCPL_ST_ADJUST = 2'b10
  } hcpl_state_e;
endpackage
`default_nettype wire

/* File: hdl/hcpl_sampler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcpl_params.svh"
// ==========================================
// averager of 300 zero-cross synchronised samples
module hcpl_sampler
  import hcpl_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic rst_in, // async reset, high
  input wire logic start_in, // zero crossing pulse that opens a window
  input wire logic sample_in, // sample strobe
  input wire hcpl_meas_s meas_in, // converted values
  output hcpl_meas_s avg_out, // window averages, registered
  output logic done_out // one pulse when a window closes
);
  logic [8:0] cnt_reg;
  logic busy_reg;
  logic [18:0] acc_i_reg, acc_g_reg, acc_v_reg;

  function automatic hcpl_adc_t avg300(input logic [18:0] s);
    avg300 = hcpl_adc_t'(s / 19'd300);
  endfunction

  // accumulate 300 samples from a zero crossing
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 9'h000;
      busy_reg <= 1'b0;
      acc_i_reg <= 19'h00000;
      acc_g_reg <= 19'h00000;
      acc_v_reg <= 19'h00000;
      avg_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (!busy_reg && start_in) begin // R08
        busy_reg <= 1'b1;
        cnt_reg <= 9'h000;
        acc_i_reg <= 19'h00000;
        acc_g_reg <= 19'h00000;
        acc_v_reg <= 19'h00000;
      end else if (busy_reg && sample_in) begin
        acc_i_reg <= acc_i_reg + 19'(meas_in.heater_current); // R09
        acc_g_reg <= acc_g_reg + 19'(meas_in.earth_leakage_current);
        acc_v_reg <= acc_v_reg + 19'(meas_in.voltage);
        if (cnt_reg == `HCPL_SAMPLES - 9'h001) begin // R08
          busy_reg <= 1'b0;
          done_out <= 1'b1;
          avg_out.heater_current <= avg300(acc_i_reg + 19'(meas_in.heater_current));
          avg_out.earth_leakage_current <= avg300(acc_g_reg + 19'(meas_in.earth_leakage_current));
          avg_out.voltage <= avg300(acc_v_reg + 19'(meas_in.voltage));
        end else begin
          cnt_reg <= cnt_reg + 9'h001;
        end
      end
    end
  end

  AST_WINDOW_LEN: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R08
    done_out |-> $past(cnt_reg) == 9'h12B)
    else $error("window closed at wrong sample count");
endmodule
`default_nettype wire

/* File: hdl/hcpl_limiter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcpl_params.svh"
// ==========================================
// cycle modulation power limiter
module hcpl_limiter
  import hcpl_pkg::*;
(
  input wire logic ref_clk_in, // 125 MHz clock
  input wire logic rst_in, // async reset, high
  input wire logic zero_cross_in, // mains zero-cross level, async pin
  input wire logic sample_in, // sample strobe from converter, same domain
  input wire hcpl_meas_s meas_in, // 10-bit converted values
  input wire logic heat_req_in, // heat requested
  input wire hcpl_adc_t limit_in, // limit current code, 0 means off
  input wire hcpl_adc_t full_current_in, // heater current at full duty
  input wire hcpl_adc_t leak_trip_in, // leakage trip threshold
  output logic heater_on_out, // heater switch gate
  output logic [3:0] duty_out, // applied duty step 0..10
  output logic tripped_out, // earth leakage trip latched
  output hcpl_meas_s avg_out, // last window averages
  output logic window_done_out // pulse per measurement window
);
  logic zc_s1_reg, zc_s2_reg, zc_s3_reg;
  logic zc_edge;
  logic [3:0] pos_reg, duty_reg, next_duty_reg;
  logic [1:0] settle_reg;
  hcpl_state_e state_reg;
  hcpl_meas_s avg_w;
  logic done_w;
  logic [14:0] pace_reg;
  logic [15:0] trip_reg;
  logic leak_over;
  hcpl_adc_t limit_eff;

  // bresenham style spread pattern: on when (pos*duty) wraps past a boundary
  function automatic logic pattern_on(input logic [3:0] d, input logic [3:0] p);
    logic [7:0] a;
    logic [7:0] b;
    a = 8'(d) * 8'(p);
    b = 8'(d) * 8'(p + 4'h1);
    pattern_on = (b / 8'd10) != (a / 8'd10);
  endfunction

  // ten times the expected average current = full current * duty
  function automatic logic [13:0] expected(input hcpl_adc_t f, input logic [3:0] d);
    expected = 14'(f) * 14'(d);
  endfunction

  // two-stage synchroniser then edge detect on stage two
  // reset high so a pin already high at release is not taken for a crossing
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      zc_s1_reg <= 1'b1;
      zc_s2_reg <= 1'b1;
      zc_s3_reg <= 1'b1;
    end else begin
      zc_s1_reg <= zero_cross_in;
      zc_s2_reg <= zc_s1_reg;
      zc_s3_reg <= zc_s2_reg;
    end
  end
  assign zc_edge = zc_s2_reg && !zc_s3_reg;

  hcpl_sampler u_sampler (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(zc_edge),
    .sample_in(sample_in),
    .meas_in(meas_in),
    .avg_out(avg_w),
    .done_out(done_w)
  );

  // position in the ten-cycle frame, advanced per zero crossing
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pos_reg <= 4'h0;
    end else if (zc_edge) begin
      pos_reg <= (pos_reg == `HCPL_FRAME_CYCLES - 4'h1) ? 4'h0 : pos_reg + 4'h1; // R01
    end
  end

  // settings above the top of the range act as the top of the range
  assign limit_eff = (limit_in > `HCPL_LIMIT_MAX) ? `HCPL_LIMIT_MAX : limit_in; // R11

  // duty chosen by the limiter, latched into duty_reg at a frame boundary
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= HCPL_ST_OFF;
      next_duty_reg <= 4'h0;
      settle_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        HCPL_ST_OFF: begin
          next_duty_reg <= 4'h0; // R06
          settle_reg <= 2'h0;
          if (heat_req_in && !tripped_out) begin
            state_reg <= HCPL_ST_SETTLE;
          end
        end
        HCPL_ST_SETTLE: begin
          if (!heat_req_in || tripped_out) begin
            state_reg <= HCPL_ST_OFF;
          end else if (done_w) begin
            // wait for windows at the applied duty
            if (duty_reg != next_duty_reg) begin
              settle_reg <= 2'h0;
            end else if (settle_reg == `HCPL_SETTLE_FRAMES - 2'h1) begin // R05
              state_reg <= HCPL_ST_ADJUST;
              settle_reg <= 2'h0;
            end else begin
              settle_reg <= settle_reg + 2'h1;
            end
          end
        end
        HCPL_ST_ADJUST: begin
          state_reg <= HCPL_ST_SETTLE;
          if (limit_in == `HCPL_LIMIT_OFF) begin
            if (next_duty_reg != `HCPL_DUTY_FULL) next_duty_reg <= next_duty_reg + 4'h1; // R11 R06
          end else if (expected(full_current_in, duty_reg) > 14'(limit_eff) * 14'd10) begin // R10
            if (next_duty_reg != 4'h0) next_duty_reg <= next_duty_reg - 4'h1; // R03
          end else if (expected(full_current_in, duty_reg) < 14'(limit_eff) * 14'd10) begin
            if (next_duty_reg != `HCPL_DUTY_FULL) next_duty_reg <= next_duty_reg + 4'h1; // R04
          end
        end
        default: state_reg <= HCPL_ST_OFF;
      endcase
    end
  end

  // apply the duty only at frame start
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      duty_reg <= 4'h0;
    end else if (zc_edge && pos_reg == `HCPL_FRAME_CYCLES - 4'h1) begin
      duty_reg <= (heat_req_in && !tripped_out) ? next_duty_reg : 4'h0; // R13 R14
    end
  end

  // heater gate changes only on a zero crossing, except that a trip forces it off on the next clock
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      heater_on_out <= 1'b0;
    end else if (tripped_out) begin
      heater_on_out <= 1'b0; // R12
    end else if (zc_edge) begin
      if (pos_reg == `HCPL_FRAME_CYCLES - 4'h1) begin
        heater_on_out <= heat_req_in && pattern_on(next_duty_reg, 4'h0); // R07 R02 R14
      end else begin
        heater_on_out <= pattern_on(duty_reg, pos_reg + 4'h1); // R02
      end
    end
  end

  // earth leakage trip: 0.2 ms pace ticks, trip well inside 7.4 s
  assign leak_over = avg_w.earth_leakage_current > leak_trip_in;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pace_reg <= 15'h0000;
      trip_reg <= 16'h0000;
      tripped_out <= 1'b0;
    end else begin
      pace_reg <= (pace_reg == 15'(`HCPL_PACE_DIV - 32'd1)) ? 15'h0000 : pace_reg + 15'h0001;
      if (!leak_over) begin
        trip_reg <= 16'h0000;
      end else if (pace_reg == 15'h0000) begin
        if (trip_reg == 16'(`HCPL_TRIP_TICKS)) begin
          tripped_out <= 1'b1; // R12
        end else begin
          trip_reg <= trip_reg + 16'h0001;
        end
      end
    end
  end

  // registered copies for the outputs
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      duty_out <= 4'h0;
      avg_out <= '0;
      window_done_out <= 1'b0;
    end else begin
      duty_out <= duty_reg;
      avg_out <= avg_w;
      window_done_out <= done_w;
    end
  end

  AST_GATE_AT_ZC: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R07
    $rose(heater_on_out) |-> $past(zc_edge))
    else $error("heater switched on away from zero crossing");
  AST_DUTY_AT_FRAME: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R13
    duty_reg != $past(duty_reg) |-> $past(zc_edge) && $past(pos_reg) == 4'h9)
    else $error("duty changed inside a frame");
  AST_POS_RANGE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R01
    pos_reg <= 4'h9)
    else $error("frame position out of range");
  AST_DUTY_MAX: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R02
    next_duty_reg <= 4'hA)
    else $error("duty above full");
  AST_NO_HEAT_OFF: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R14
    (zc_edge && pos_reg == 4'h9 && !heat_req_in) |=> duty_reg == 4'h0 && !heater_on_out)
    else $error("heater left on without heat request");
  AST_TRIP_OFF: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R12
    tripped_out |=> !heater_on_out)
    else $error("heater on after trip");
  AST_STEP_ONE: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R03 R04
    $past(state_reg) == HCPL_ST_ADJUST |-> (next_duty_reg - $past(next_duty_reg) <= 4'h1
      || $past(next_duty_reg) - next_duty_reg <= 4'h1))
    else $error("duty moved more than one step");
  AST_SOFT_START: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R06
    ($past(state_reg) == HCPL_ST_OFF && state_reg == HCPL_ST_SETTLE) |-> next_duty_reg == 4'h0)
    else $error("soft start not from zero");
  AST_RAMP_FROM_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R06
    ($past(duty_reg) == 4'h0 && duty_reg != 4'h0) |-> duty_reg == 4'h1)
    else $error("duty left zero by more than one step");
  AST_SETTLE_FIRST: assert property (@(posedge ref_clk_in) disable iff (rst_in) // R05
    state_reg == HCPL_ST_ADJUST |-> $past(done_w) && $past(duty_reg) == $past(next_duty_reg))
    else $error("adjusted before settling");
endmodule
`default_nettype wire

/* File: dv/hcpl_mains_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// mains zero-cross, converter strobe and heater current model
module hcpl_mains_model
  import hcpl_pkg::*;
#(
  parameter int CYC = 60 // clocks per power cycle
)(
  input wire logic ref_clk_in, // clock
  input wire logic heater_on_in, // heater gate from the block
  input wire hcpl_adc_t full_in, // current drawn while conducting
  input wire hcpl_adc_t volt_in, // line voltage code
  output logic zero_cross_out, // square wave, rise is a crossing
  output logic sample_out, // 30 strobes per power cycle
  output hcpl_meas_s meas_out // sensed values
);
  int cnt = 0;
  // phase counter, free running like the mains
  always_ff @(posedge ref_clk_in) begin
    cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
    zero_cross_out <= (cnt < CYC / 2);
    sample_out <= (cnt % (CYC / 30) == 0);
  end
  // current flows only while the switch conducts, no leakage
  always_ff @(posedge ref_clk_in) begin
    meas_out <= '{heater_on_in ? full_in : 10'h000, 10'h000, volt_in};
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench for the heater cycle power limiter
module tb_top
  import hcpl_pkg::*;
;
  localparam int CYC = 60;
  localparam int FRM = 10 * CYC; // clocks per frame
  localparam hcpl_adc_t FULL = 10'h064;
  localparam hcpl_adc_t VOLT = 10'h1F0;
  typedef struct packed {hcpl_adc_t lim; logic [3:0] duty;} hcpl_row_s;
  // limit code beside the duty it should settle at
  hcpl_row_s rows [3] = '{'{10'h000, 4'hA}, '{10'h032, 4'h5}, '{10'h014, 4'h2}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic heat = 1'b0;
  hcpl_adc_t lim = 10'h000;
  logic zc, smp, hon, trip, wdone;
  logic [3:0] duty;
  hcpl_meas_s meas, avg;
  int n_fail = 0;
  int check_count = 0;
  logic zc_d = 1'b0;
  logic hon_d = 1'b0;
  logic [3:0] duty_d = 4'h0;
  int age = 0;
  int since = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  hcpl_mains_model #(.CYC(CYC)) mains (.ref_clk_in(clk), .heater_on_in(hon), .full_in(FULL),
    .volt_in(VOLT), .zero_cross_out(zc), .sample_out(smp), .meas_out(meas));
  hcpl_limiter dut (.ref_clk_in(clk), .rst_in(rst), .zero_cross_in(zc), .sample_in(smp),
    .meas_in(meas), .heat_req_in(heat), .limit_in(lim), .full_current_in(FULL),
    .leak_trip_in(10'h050), .heater_on_out(hon), .duty_out(duty), .tripped_out(trip),
    .avg_out(avg), .window_done_out(wdone));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // count conducting clocks over ten power cycles
  task automatic frame_on(input int exp, input string msg);
    int n;
    n = 0;
    repeat (FRM) begin
      @(negedge clk);
      if (hon === 1'b1) n++;
    end
    chk(n, exp * CYC, msg);
  endtask

  task automatic wait_duty(input logic [3:0] exp, input int hold);
    int k;
    k = 0;
    while (duty !== exp && k < 40 * FRM) begin
      @(negedge clk);
      k++;
    end
    repeat (hold) @(negedge clk);
  endtask

  // switching and duty moves must sit on crossings and move one step after settling
  always @(posedge clk) begin
    zc_d <= zc;
    hon_d <= hon;
    duty_d <= duty;
    age <= (zc && !zc_d) ? 0 : age + 1;
    since <= (duty !== duty_d) ? 0 : since + 1;
    if (!rst && hon !== hon_d) chk(age <= 8, 1, "switch off crossing");
    if (!rst && heat && duty !== duty_d) begin
      chk(age <= 8, 1, "duty mid frame");
      chk(since >= 2 * FRM - 8, 1, "duty not settled");
      chk((duty > duty_d) ? duty - duty_d : duty_d - duty, 1, "duty step");
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({hon, trip, duty}, 0, "reset outputs");
    chk({wdone, avg}, 0, "reset averages");
    foreach (rows[i]) begin
      @(posedge clk);
      lim <= rows[i].lim;
      heat <= 1'b1;
      wait_duty(rows[i].duty, 2 * FRM);
      chk(duty, rows[i].duty, "settled duty");
      frame_on(rows[i].duty, "on cycles per frame");
    end
    // window averages of voltage, leakage and heater current
    while (wdone !== 1'b1) @(negedge clk);
    chk(avg.voltage, VOLT, "voltage average");
    chk(avg.earth_leakage_current, 0, "leakage average");
    chk(avg.heater_current, FULL * rows[2].duty / 10, "current average");
    // heat withdrawn keeps the heater dark
    @(posedge clk);
    heat <= 1'b0;
    repeat (2 * FRM) @(negedge clk);
    chk(duty, 0, "duty without heat");
    frame_on(0, "on cycles without heat");
    // heat again, reset in mid ramp, restart from zero
    @(posedge clk);
    lim <= 10'h000;
    heat <= 1'b1;
    repeat (6 * FRM) @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk({hon, duty}, 0, "outputs in reset");
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(duty, 0, "soft start origin");
    wait_duty(4'h1, 0);
    chk(duty, 1, "first soft start step");
    chk(trip, 0, "no trip without leakage");
    test_done();
  end

  // watchdog against a hung ramp
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
